// File: common/bpsd_pkg.sv
//****************************************************************
// Purpose: Shared constants for the bridge steering block
// Assumes: One clock (ref_clk) equal to the oscillator period
// Notes:   Offsets, field positions and reset values live here
//****************************************************************
package bpsd_pkg;

   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [7:0] BPSD_CFG_OFS     = 8'h18;
   localparam logic [7:0] BPSD_ASD_OFS     = 8'h19;
   localparam logic [7:0] BPSD_CFG_RST     = 8'h00;
   localparam logic [7:0] BPSD_ASD_RST     = 8'h00;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int BPSD_CFG_RESTART_BIT = 7;
   localparam int BPSD_CFG_DB_MSB      = 6;
   localparam int BPSD_ASD_STATUS_BIT  = 7;
   localparam int BPSD_ASD_INT_BIT     = 6;
   localparam int BPSD_ASD_B4_BIT      = 4;
   localparam int BPSD_ASD_AC_LSB      = 2;
   localparam int BPSD_ASD_BD_LSB      = 0;
   localparam int BPSD_DB_W            = 7;
   localparam int BPSD_CNT_W           = 16;

   // ***************************************************
   // Timing
   // ***************************************************
   localparam int BPSD_TOSC_NS        = 10;
   localparam int BPSD_CLK_NS         = 10;
   // Oscillator periods per instruction cycle
   localparam int BPSD_TOSC_PER_TCY   = 4;
   localparam int BPSD_TCY_CYCLES     = (BPSD_TOSC_PER_TCY * BPSD_TOSC_NS) / BPSD_CLK_NS;
   // Direction-change lead, in oscillator periods per prescale unit
   localparam int BPSD_LEAD_TOSC      = 4;
   localparam int BPSD_LEAD_UNIT      = (BPSD_LEAD_TOSC * BPSD_TOSC_NS) / BPSD_CLK_NS;
   localparam int BPSD_PRESCALE_1     = 1;
   localparam int BPSD_PRESCALE_4     = 4;
   localparam int BPSD_PRESCALE_16    = 16;

   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [1:0] {
      BPSD_MODE_SINGLE = 2'h0,
      BPSD_MODE_FWD    = 2'h1,
      BPSD_MODE_HALF   = 2'h2,
      BPSD_MODE_REV    = 2'h3
   } bpsd_mode_e;

   // Shutdown state codes for a pin pair
   localparam logic [1:0] BPSD_SS_LOW  = 2'h0;
   localparam logic [1:0] BPSD_SS_HIGH = 2'h1;

endpackage : bpsd_pkg

// File: rtl/bpsd_sync2.sv
//****************************************************************
// Purpose: Two-flop synchroniser, one per bit
// Assumes: Inputs are asynchronous pins
// Notes:   First stage feeds only the second stage
//****************************************************************
module bpsd_sync2 #(
   parameter int W = 2
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   import bpsd_pkg::*;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_reg;
         logic stab_reg;
         // Two stages, reset to idle-high pin level
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               meta_reg <= 1'b1;
               stab_reg <= 1'b1;
            end else begin
               meta_reg <= async_in[i];
               stab_reg <= meta_reg;
            end
         end
         assign sync_out[i] = stab_reg;
      end
   endgenerate

endmodule : bpsd_sync2

// File: rtl/bpsd_deadband.sv
//****************************************************************
// Purpose: Rising-edge delay for the two half-bridge outputs
// Assumes: tick is a one-cycle instruction-cycle enable
// Notes:   Falling edges pass with one cycle latency only
//****************************************************************
module bpsd_deadband #(
   parameter int DW = 7
) (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // Control
   input  wire logic          tick,
   input  wire logic [DW-1:0] delay,
   // Requests and delayed outputs
   input  wire logic [1:0]    req,
   output logic      [1:0]    dly_out
);
   import bpsd_pkg::*;

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_ch
         logic [DW-1:0] cnt_reg;
         logic          out_reg;
         always_ff @(posedge ref_clk) begin
            if (rst || !req[i]) begin
               cnt_reg <= '0;
               out_reg <= 1'b0;
            end else if (!out_reg) begin
               if (cnt_reg == delay) begin
                  out_reg <= 1'b1;
               end else if (tick) begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
         end
         assign dly_out[i] = out_reg;
      end
   endgenerate

endmodule : bpsd_deadband

// File: rtl/bpsd_bridge_top.sv
//****************************************************************
// Purpose: Output steering: direction, dead band, auto-shutdown
// Assumes: ref_clk is the oscillator; period_start from timer
// Notes:   Shutdown pin override is combinational on purpose
//****************************************************************
//
// Our own choice: strobed register access.
module bpsd_bridge_top
   import bpsd_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // PWM engine side
   input  wire logic        period_start,
   input  wire logic        pwm_mod,
   input  wire logic [1:0]  timer_prescale_select,
   input  wire logic [1:0]  output_mode,
   // Shutdown pins, active low
   input  wire logic        shdn_int_n,
   input  wire logic        shdn_b4_n,
   // Bridge pins
   output logic             bridge_out_a,
   output logic             bridge_out_a_oe,
   output logic             bridge_out_b,
   output logic             bridge_out_b_oe,
   output logic             bridge_out_c,
   output logic             bridge_out_c_oe,
   output logic             bridge_out_d,
   output logic             bridge_out_d_oe
);

   // ***************************************************
   // Declarations
   // ***************************************************
   logic [7:0]            cfg_reg;
   logic                  status_reg;
   logic                  status_next;
   logic                  sel_int_reg;
   logic                  sel_b4_reg;
   logic [1:0]            ss_ac_reg;
   logic [1:0]            ss_bd_reg;
   logic [7:0]            rdata_reg;
   logic [1:0]            div_reg;
   logic                  tcy_tick;
   logic [BPSD_CNT_W-1:0] cyc_cnt_reg;
   logic [BPSD_CNT_W-1:0] per_len_reg;
   logic [BPSD_CNT_W-1:0] lead_cycles;
   logic [BPSD_CNT_W-1:0] lead_point;
   logic                  dir_reg;
   logic                  dir_req;
   logic                  dir_pending;
   logic                  lead_win;
   logic                  sd_period_reg;
   logic [1:0]            pins_sync;
   logic                  cause_sync;
   logic                  cause_async;
   logic                  hold_sd;
   logic                  wr_cfg;
   logic                  wr_asd;
   logic                  rd_cfg;
   logic                  rd_asd;
   logic [7:0]            asd_view;
   logic [1:0]            db_req;
   logic [1:0]            db_out;
   logic [3:0]            norm_next;
   logic [3:0]            norm_reg;
   logic [3:0]            sd_val;
   logic [3:0]            sd_oe;
   logic [3:0]            pin_val;
   logic [3:0]            pin_oe;
   bpsd_mode_e            mode;

   // ***************************************************
   // Register decode
   // ***************************************************
   // Address matches for the two registers
   assign wr_cfg = reg_wr && (reg_addr == BPSD_CFG_OFS);
   assign wr_asd = reg_wr && (reg_addr == BPSD_ASD_OFS);
   assign rd_cfg = reg_rd && (reg_addr == BPSD_CFG_OFS);
   assign rd_asd = reg_rd && (reg_addr == BPSD_ASD_OFS);

   // Read view of shutdown control, bit 5 reads zero
   assign asd_view = {status_reg, sel_int_reg, 1'b0, sel_b4_reg, ss_ac_reg, ss_bd_reg};

   // Configuration register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_reg <= BPSD_CFG_RST;
      end else if (wr_cfg) begin
         cfg_reg <= reg_wdata;
      end
   end

   // Shutdown control fields other than status
   // source selects bits 6 and 4
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sel_int_reg <= BPSD_ASD_RST[BPSD_ASD_INT_BIT];
         sel_b4_reg  <= BPSD_ASD_RST[BPSD_ASD_B4_BIT];
         ss_ac_reg   <= BPSD_ASD_RST[BPSD_ASD_AC_LSB +: 2];
         ss_bd_reg   <= BPSD_ASD_RST[BPSD_ASD_BD_LSB +: 2];
      end else if (wr_asd) begin
         sel_int_reg <= reg_wdata[BPSD_ASD_INT_BIT];
         sel_b4_reg  <= reg_wdata[BPSD_ASD_B4_BIT];
         ss_ac_reg   <= reg_wdata[BPSD_ASD_AC_LSB +: 2];
         ss_bd_reg   <= reg_wdata[BPSD_ASD_BD_LSB +: 2];
      end
   end

   // Read data, one cycle after the strobe, zero elsewhere
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (rd_cfg) begin
         rdata_reg <= cfg_reg;
      end else if (rd_asd) begin
         rdata_reg <= asd_view;
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign reg_rdata = rdata_reg;

   // ***************************************************
   // Instruction cycle enable
   // ***************************************************
   // Divide oscillator by four into a one-cycle tick
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_reg <= 2'h0;
      end else if (div_reg == 2'(BPSD_TCY_CYCLES - 1)) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end
   assign tcy_tick = (div_reg == 2'(BPSD_TCY_CYCLES - 1));

   // ***************************************************
   // Shutdown detection
   // ***************************************************
   // synchronise pins for status
   bpsd_sync2 #(
      .W (2)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in ({shdn_int_n, shdn_b4_n}),
      .sync_out (pins_sync)
   );

   assign cause_sync  = (sel_int_reg && !pins_sync[1]) || (sel_b4_reg && !pins_sync[0]);
   // raw pin path for immediate forcing
   assign cause_async = (sel_int_reg && !shdn_int_n) || (sel_b4_reg && !shdn_b4_n);

   // Status bit next value, hardware set wins
   always_comb begin
      status_next = status_reg;
      if (cause_sync) begin
         status_next = 1'b1;
      end else if (wr_asd) begin
         status_next = reg_wdata[BPSD_ASD_STATUS_BIT];
      end else if (cfg_reg[BPSD_CFG_RESTART_BIT]) begin
         status_next = 1'b0;
      end
   end

   // Status register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_reg <= BPSD_ASD_RST[BPSD_ASD_STATUS_BIT];
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sd_period_reg <= 1'b0;
      end else if (period_start) begin
         sd_period_reg <= status_next;
      end else if (status_reg) begin
         sd_period_reg <= 1'b1;
      end
   end

   assign hold_sd = cause_async || status_reg || sd_period_reg;

   // ***************************************************
   // Period measure and direction change
   // ***************************************************
   // Cycle count within period and last period length
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cyc_cnt_reg <= '0;
         per_len_reg <= '0;
      end else if (period_start) begin
         cyc_cnt_reg <= '0;
         per_len_reg <= cyc_cnt_reg + 1'b1;
      end else begin
         cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
      end
   end

   assign lead_cycles = (timer_prescale_select == 2'h0) ? BPSD_CNT_W'(BPSD_LEAD_UNIT * BPSD_PRESCALE_1)
                      : (timer_prescale_select == 2'h1) ? BPSD_CNT_W'(BPSD_LEAD_UNIT * BPSD_PRESCALE_4)
                      : BPSD_CNT_W'(BPSD_LEAD_UNIT * BPSD_PRESCALE_16);
   assign lead_point  = (per_len_reg > lead_cycles) ? per_len_reg - lead_cycles : '0;

   // Requested direction from the mode bits
   assign mode        = bpsd_mode_e'(output_mode);
   assign dir_req     = (mode == BPSD_MODE_REV);
   assign dir_pending = (mode == BPSD_MODE_FWD || mode == BPSD_MODE_REV) && (dir_req != dir_reg);
   assign lead_win    = dir_pending && (cyc_cnt_reg >= lead_point);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dir_reg <= 1'b0;
      end else if (period_start) begin
         dir_reg <= dir_req;
      end
   end

   // ***************************************************
   // Half-bridge dead band
   // ***************************************************
   // seven-bit count in instruction cycles
   assign db_req = (mode == BPSD_MODE_HALF) ? {!pwm_mod, pwm_mod} : 2'h0;

   bpsd_deadband #(
      .DW (BPSD_DB_W)
   ) u_db (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (tcy_tick),
      .delay   (cfg_reg[BPSD_CFG_DB_MSB:0]),
      .req     (db_req),
      .dly_out (db_out)
   );

   // ***************************************************
   // Normal drive pattern {d, c, b, a}
   // ***************************************************
   always_comb begin
      norm_next = 4'h0;
      case (mode)
         BPSD_MODE_SINGLE: begin
            norm_next = {3'h0, pwm_mod};
         end
         BPSD_MODE_HALF: begin
            norm_next = {2'h0, db_out[1], db_out[0]};
         end
         default: begin
            // forward A on D pwm, reverse C on B pwm
            if (lead_win) begin
               norm_next = {1'b0, !dir_reg, 1'b0, dir_reg};
            end else if (dir_reg) begin
               norm_next = {1'b0, 1'b1, pwm_mod, 1'b0};
            end else begin
               norm_next = {pwm_mod, 1'b0, 1'b0, 1'b1};
            end
         end
      endcase
   end

   // Register the normal pattern
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         norm_reg <= 4'h0;
      end else begin
         norm_reg <= norm_next;
      end
   end

   // ***************************************************
   // Pin override
   // ***************************************************
   // pair shutdown levels and enables
   assign sd_val = {ss_bd_reg == BPSD_SS_HIGH, ss_ac_reg == BPSD_SS_HIGH,
                    ss_bd_reg == BPSD_SS_HIGH, ss_ac_reg == BPSD_SS_HIGH};
   assign sd_oe  = {!ss_bd_reg[1], !ss_ac_reg[1], !ss_bd_reg[1], !ss_ac_reg[1]};

   assign pin_val = hold_sd ? sd_val : norm_reg;
   assign pin_oe  = hold_sd ? sd_oe  : 4'hF;

   assign bridge_out_a    = pin_val[0];
   assign bridge_out_b    = pin_val[1];
   assign bridge_out_c    = pin_val[2];
   assign bridge_out_d    = pin_val[3];
   assign bridge_out_a_oe = pin_oe[0];
   assign bridge_out_b_oe = pin_oe[1];
   assign bridge_out_c_oe = pin_oe[2];
   assign bridge_out_d_oe = pin_oe[3];

endmodule : bpsd_bridge_top

// File: testbench/bpsd_bridge_top_sva.sv
// Purpose: Port-level checks of the bridge steering block
// Assumes: Register writes are seen on the same port as the design
// Notes:   Shadows firmware writes to predict fields and forcing
module bpsd_bridge_top_sva
   import bpsd_pkg::*;
(
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // PWM engine and shutdown pins
   input wire logic       period_start,
   input wire logic       pwm_mod,
   input wire logic [1:0] timer_prescale_select,
   input wire logic [1:0] output_mode,
   input wire logic       shdn_int_n,
   input wire logic       shdn_b4_n,
   // Bridge pins
   input wire logic       bridge_out_a,
   input wire logic       bridge_out_a_oe,
   input wire logic       bridge_out_b,
   input wire logic       bridge_out_b_oe,
   input wire logic       bridge_out_c,
   input wire logic       bridge_out_c_oe,
   input wire logic       bridge_out_d,
   input wire logic       bridge_out_d_oe
);
   logic [7:0] cfg_sh;
   logic [6:0] asd_sh;
   logic       forced;
   logic [1:0] cause_cnt;
   logic [2:0] half_cnt;
   logic [1:0] per_cnt;
   logic [1:0] mode_prev;
   // Decodes of writes and of a live shutdown cause
   wire wr_cfg = reg_wr && reg_addr == BPSD_CFG_OFS;
   wire wr_asd = reg_wr && reg_addr == BPSD_ASD_OFS;
   wire cause  = (asd_sh[6] && !shdn_int_n) || (asd_sh[4] && !shdn_b4_n);
   wire quiet  = !forced && !asd_sh[6] && !asd_sh[4];
   wire unmap  = reg_addr != BPSD_CFG_OFS && reg_addr != BPSD_ASD_OFS;
   // Shadow registers and run-length counters
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_sh    <= 8'h00;
         asd_sh    <= 7'h00;
         forced    <= 1'b0;
         cause_cnt <= 2'h0;
         half_cnt  <= 3'h0;
         per_cnt   <= 2'h0;
         mode_prev <= 2'h0;
      end else begin
         cfg_sh    <= wr_cfg ? reg_wdata : cfg_sh;
         asd_sh    <= wr_asd ? {reg_wdata[6], 1'b0, reg_wdata[4:0]} : asd_sh;
         forced    <= forced || (wr_asd && reg_wdata[7]);
         cause_cnt <= !cause ? 2'h0 : (cause_cnt == 2'h3 ? 2'h3 : cause_cnt + 2'h1);
         half_cnt  <= output_mode != BPSD_MODE_HALF ? 3'h0 :
                      (half_cnt[2] ? half_cnt : half_cnt + 3'h1);
         per_cnt   <= output_mode != mode_prev ? 2'h0 :
                      ((period_start && per_cnt != 2'h3) ? per_cnt + 2'h1 : per_cnt);
         mode_prev <= output_mode;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ***************************************
   // Register port
   // ***************************************
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   a_rd_unmapped: assert property (reg_rd && unmap |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_cfg_readback: assert property (
      reg_rd && reg_addr == BPSD_CFG_OFS |=> reg_rdata == $past(cfg_sh))
      else $error("config read back wrong");
   a_asd_fields: assert property (
      reg_rd && reg_addr == BPSD_ASD_OFS |=> reg_rdata[6:0] == $past(asd_sh))
      else $error("shutdown fields read back wrong");
   a_status_set: assert property (
      reg_rd && reg_addr == BPSD_ASD_OFS && cause_cnt == 2'h3 |=> reg_rdata[7])
      else $error("status not set by shutdown");
   // ***************************************
   // Pins
   // ***************************************
   a_force_ac: assert property (cause && output_mode != BPSD_MODE_SINGLE |->
      bridge_out_a_oe == !asd_sh[3] && bridge_out_c_oe == !asd_sh[3] &&
      (asd_sh[3] || (bridge_out_a == asd_sh[2] && bridge_out_c == asd_sh[2])))
      else $error("pair a c not forced");
   a_force_bd: assert property (cause && output_mode != BPSD_MODE_SINGLE |->
      bridge_out_b_oe == !asd_sh[1] && bridge_out_d_oe == !asd_sh[1] &&
      (asd_sh[1] || (bridge_out_b == asd_sh[0] && bridge_out_d == asd_sh[0])))
      else $error("pair b d not forced");
   a_half_rise: assert property (
      quiet && half_cnt == 3'h4 && $rose(bridge_out_a) |-> $past(pwm_mod, 2))
      else $error("half output rose without request");
   a_half_fall: assert property (
      quiet && half_cnt == 3'h4 && $fell(pwm_mod) |-> ##2 !bridge_out_a)
      else $error("half output fall delayed");
   a_fwd_drive: assert property (quiet && per_cnt == 2'h3 &&
      output_mode == BPSD_MODE_FWD && $past(output_mode) == BPSD_MODE_FWD |->
      bridge_out_a && !bridge_out_b && !bridge_out_c && bridge_out_d == $past(pwm_mod))
      else $error("forward pattern wrong");
   a_rev_drive: assert property (quiet && per_cnt == 2'h3 &&
      output_mode == BPSD_MODE_REV && $past(output_mode) == BPSD_MODE_REV |->
      bridge_out_c && !bridge_out_a && !bridge_out_d && bridge_out_b == $past(pwm_mod))
      else $error("reverse pattern wrong");
endmodule : bpsd_bridge_top_sva

bind bpsd_bridge_top bpsd_bridge_top_sva bpsd_bridge_top_sva_i (.*);

// File: testbench/bpsd_switch_model.sv
// Purpose: Power switch drivers behind the four bridge pins
// Assumes: Each pin line has a pull-down keeping its switch off
// Notes:   Flags high side a and low side b on together
module bpsd_switch_model (
   // Bridge pins and enables, order d c b a
   input  wire logic [3:0] pin,
   input  wire logic [3:0] pin_oe,
   // Switch gates and shoot-through flag
   output logic      [3:0] gate,
   output logic            shoot
);
   // Released pin falls to its pull-down
   assign gate  = pin & pin_oe;
   // Upper a with lower b shorts the supply
   assign shoot = gate[0] & gate[1];
endmodule : bpsd_switch_model

// File: testbench/bpsd_bridge_top_bench.sv
// Purpose: Scenario bench for the bridge steering block
// Assumes: Timer stand-in gives 80-cycle periods, 20-cycle duty
// Notes:   Each scenario is one task that judges its own results
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module bpsd_bridge_top_bench
   import bpsd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk, rst, reg_wr, reg_rd, period_start, pwm_mod, shdn_int_n, shdn_b4_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] timer_prescale_select, output_mode;
   logic       a, a_oe, b, b_oe, c, c_oe, d, d_oe, shoot;
   logic [3:0] gate;
   wire  [3:0] pins = {d, c, b, a};
   wire  [3:0] oes  = {d_oe, c_oe, b_oe, a_oe};
   int         fails = 0, checks_done = 0, per = 80, duty = 20, pcnt = 0;

   bpsd_bridge_top bpsd_bridge_top_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .period_start(period_start), .pwm_mod(pwm_mod),
      .timer_prescale_select(timer_prescale_select), .output_mode(output_mode),
      .shdn_int_n(shdn_int_n), .shdn_b4_n(shdn_b4_n), .bridge_out_a(a), .bridge_out_a_oe(a_oe),
      .bridge_out_b(b), .bridge_out_b_oe(b_oe), .bridge_out_c(c), .bridge_out_c_oe(c_oe),
      .bridge_out_d(d), .bridge_out_d_oe(d_oe));
   bpsd_switch_model bpsd_switch_model_i (.pin(pins), .pin_oe(oes), .gate(gate), .shoot(shoot));

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Timer stand-in: period pulse and modulated level
   always @(posedge ref_clk) begin
      pcnt         <= (pcnt >= per - 1) ? 0 : pcnt + 1;
      period_start <= (pcnt >= per - 1);
      pwm_mod      <= (pcnt < duty);
   end
   // Half bridge must never short the supply
   always @(negedge ref_clk) begin
      if (!rst && output_mode == BPSD_MODE_HALF) `CHK("shoot", 1'b0, shoot)
   end
   // ***************************************
   // Bus and helper tasks
   // ***************************************
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge ref_clk);
      reg_addr  <= ad;
      reg_wdata <= dt;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rchk(input logic [7:0] ad, input logic [7:0] ex, input string nm);
      @(posedge ref_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(negedge ref_clk);
      `CHK(nm, ex, reg_rdata)
   endtask : rchk
   task automatic to_period;
      int k = 0;
      do begin @(negedge ref_clk); k++; end while (period_start !== 1'b1 && k < 400);
   endtask : to_period
   task automatic count(input int idx, input int n, output int cn);
      cn = 0;
      repeat (n) begin @(negedge ref_clk); cn += pins[idx]; end
   endtask : count
   // ***************************************
   // Scenarios
   // ***************************************
   task automatic t_regs;
      rchk(BPSD_CFG_OFS, BPSD_CFG_RST, "cfg reset");
      rchk(BPSD_ASD_OFS, BPSD_ASD_RST, "asd reset");
      wr(BPSD_CFG_OFS, 8'hA5);
      rchk(BPSD_CFG_OFS, 8'hA5, "cfg rw");
      wr(BPSD_ASD_OFS, 8'h7F);
      rchk(BPSD_ASD_OFS, 8'h5F, "asd rw");
      wr(8'h1A, 8'hFF);
      rchk(8'h1A, 8'h00, "unmapped");
      rchk(BPSD_CFG_OFS, 8'hA5, "cfg kept");
      wr(BPSD_CFG_OFS, 8'h00);
      wr(BPSD_ASD_OFS, 8'h00);
      $display("done regs");
   endtask : t_regs
   task automatic t_half;
      int cn;
      @(posedge ref_clk);
      output_mode <= BPSD_MODE_HALF;
      wr(BPSD_CFG_OFS, 8'h02);
      to_period;
      to_period;
      count(0, per, cn);
      `CHK("half width", 1'b1, cn >= duty - 9 && cn <= duty - 5)
      wr(BPSD_CFG_OFS, 8'h06);
      to_period;
      to_period;
      count(0, per, cn);
      `CHK("band over duty", 0, cn)
      $display("done half");
   endtask : t_half
   task automatic t_full;
      int cn, m, fin;
      wr(BPSD_CFG_OFS, 8'h00);
      @(posedge ref_clk);
      output_mode <= BPSD_MODE_FWD;
      to_period;
      to_period;
      count(3, per, cn);
      `CHK("fwd d width", duty, cn)
      count(0, per, cn);
      `CHK("fwd a width", per, cn)
      for (int p = 0; p < 3; p++) begin
         to_period;
         repeat (10) @(posedge ref_clk);
         timer_prescale_select <= p[1:0];
         output_mode <= p[0] ? BPSD_MODE_FWD : BPSD_MODE_REV; // duty kept low
         cn = 0;
         m = 0;
         fin = 0;
         // Lead pattern runs through the first cycle after the period pulse
         while (fin < 2) begin
            @(negedge ref_clk);
            fin += (fin > 0 || period_start);
            cn += pins[p[0] ? 0 : 2];
            m += pins[p[0] ? 0 : 2] & (pins[1] | pins[3] | pins[p[0] ? 2 : 0]);
         end
         `CHK("lead length", 4 << (2 * p), cn)
         `CHK("lead quiet", 0, m)
         count(p[0] ? 3 : 1, per, cn);
         `CHK("new direction duty", duty, cn)
      end
      to_period;
      to_period;
      $display("done full");
   endtask : t_full
   task automatic t_shdn;
      @(posedge ref_clk);
      output_mode <= BPSD_MODE_FWD;
      wr(BPSD_ASD_OFS, 8'h46);
      @(posedge ref_clk);
      shdn_int_n <= 1'b0;
      #1 `CHK("forced gates", 4'b0101, gate)
      `CHK("forced enables", 4'b0101, oes)
      repeat (4) @(posedge ref_clk);
      rchk(BPSD_ASD_OFS, 8'hC6, "status set");
      wr(BPSD_ASD_OFS, 8'h46);
      rchk(BPSD_ASD_OFS, 8'hC6, "clear refused");
      @(posedge ref_clk);
      shdn_int_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rchk(BPSD_ASD_OFS, 8'hC6, "status held");
      to_period;
      wr(BPSD_ASD_OFS, 8'h46);
      rchk(BPSD_ASD_OFS, 8'h46, "firmware clear");
      `CHK("held to period", 4'b0101, oes)
      to_period;
      repeat (2) @(negedge ref_clk);
      `CHK("resumed", 4'b1111, oes)
      wr(BPSD_CFG_OFS, 8'h80);
      wr(BPSD_ASD_OFS, 8'h10);
      @(posedge ref_clk);
      shdn_b4_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rchk(BPSD_ASD_OFS, 8'h90, "second source");
      `CHK("driven low", 4'b0000, gate)
      @(posedge ref_clk);
      shdn_b4_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rchk(BPSD_ASD_OFS, 8'h10, "auto restart");
      wr(BPSD_CFG_OFS, 8'h00);
      wr(BPSD_ASD_OFS, 8'h80);
      repeat (2) @(negedge ref_clk);
      `CHK("forced by write", 4'b0000, gate)
      rchk(BPSD_ASD_OFS, 8'h80, "forced status");
      wr(BPSD_ASD_OFS, 8'h00);
      @(posedge ref_clk);
      shdn_int_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rchk(BPSD_ASD_OFS, 8'h00, "no source");
      $display("done shutdown");
   endtask : t_shdn
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   // Main sequence
   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd} = 2'h0;
      {shdn_int_n, shdn_b4_n} = 2'h3;
      {reg_addr, reg_wdata} = 16'h0000;
      timer_prescale_select = 2'h0;
      output_mode = BPSD_MODE_SINGLE;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs;
      t_half;
      t_full;
      t_shdn;
      finish_test;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      finish_test;
   end
endmodule : bpsd_bridge_top_bench
